// ===== logic/csfr_core_bank.sv
// core special-function register bank on the cpu data-space paths
//
// What this block does
// - decode byte addresses 0000h-07FFh as sfr space
// - unimplemented sfr addresses read as zero
// - used regions are aligned 32-byte areas
// - core low in 000h, timers 100h, system 700h
// - status: digit carry, priority, repeat, alu flags
// - core control: priority bit 3, visibility bit 2
// - registers grouped by module, not interleaved
// - byte write touches only the addressed lane
// - misaligned word access traps, store suppressed
`timescale 1ns/1ps
module csfr_core_bank
   import csfr_pkg::*;
(
   input wire logic clk_sys,          // system clock, 200 mhz
   input wire logic rst,              // synchronous reset, high
   input wire logic rdEn,             // read request from read address unit
   input wire logic [15:0] rdAddr,    // read byte address
   input wire logic rdByte,           // read is byte wide
   input wire logic wrEn,             // write request from write address unit
   input wire logic [15:0] wrAddr,    // write byte address
   input wire logic wrByte,           // write is byte wide
   input wire logic [15:0] wrData,    // write data, byte writes in low lane
   output logic [15:0] rdData,        // read answer, one cycle after rdEn
   output logic rdValid,              // read answer valid pulse
   output logic sfrSpaceHit,          // last read lay in the sfr space
   output logic sfrRegionHit,         // last read lay in a used region
   output logic addrErr,              // misaligned word access pulse
   output logic [3:0] cpuPriority,    // four-bit cpu priority level
   output logic visEnable,            // program space visibility on
   output logic repeatActive          // repeat loop in progress
);

   // ----------------------------------------------------------------
   // types and functions
   // ----------------------------------------------------------------
   typedef logic [CSFR_IDX_W-1:0] csfr_idx_t;    // register index
   typedef struct packed {
      logic hit;                                 // address names a register
      csfr_idx_t idx;                            // which one
   } csfr_hit_s;

   // shared by both paths; the even word address is what selects
   function automatic csfr_hit_s csfrLookup(input logic [15:0] addr);
      csfr_hit_s res;
      res.hit = 1'b0;
      res.idx = '0;
      for (int i = 0; i < CSFR_REG_COUNT; i++) begin
         if ({addr[15:1], 1'b0} == CSFR_REG_ADDR[i]) begin
            res.hit = 1'b1;
            res.idx = csfr_idx_t'(i);
         end
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   csfr_hit_s rdHit;                       // decode of the read address
   csfr_hit_s wrHit;                       // decode of the write address
   logic [15:0] regQ [CSFR_REG_COUNT];     // register contents
   logic [16*CSFR_REG_COUNT-1:0] regFlat;  // all contents, for checks
   logic [15:0] wrLane;                    // write data placed on its lane
   logic wrLoOk;                           // access may touch the low lane
   logic wrHiOk;                           // access may touch the high lane
   logic rdSpace;                          // read address in sfr space
   logic rdRegion;                         // read address in a used region
   logic [15:0] rdWord;                    // selected register word
   logic [15:0] rdData_next;               // next read answer
   logic rdMisaligned;                     // word read at odd address
   logic wrMisaligned;                     // word write at odd address

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   always_comb begin
      rdHit = csfrLookup(rdAddr);
      wrHit = csfrLookup(wrAddr);
   end

   csfr_region_map u_rd_region (
      .addr(rdAddr),
      .inSpace(rdSpace),
      .regionUsed(rdRegion)
   );

   // ----------------------------------------------------------------
   // write lane steering
   // ----------------------------------------------------------------
   // a byte write arrives in the low lane and is copied to both;
   // the lane enables decide which side really loads
   always_comb begin
      wrMisaligned = !wrByte && wrAddr[0];
      wrLane = wrByte ? {wrData[7:0], wrData[7:0]} : wrData;
      wrLoOk = wrEn && wrHit.hit && !wrAddr[0];
      wrHiOk = wrEn && wrHit.hit && (wrByte ? wrAddr[0] : !wrAddr[0]);
   end

   // ----------------------------------------------------------------
   // register array
   // ----------------------------------------------------------------
   // an address that matches no register enables no lane
   generate
      for (genvar g = 0; g < CSFR_REG_COUNT; g++) begin : gen_reg
         csfr_word_reg #(
            .RESET_VAL(CSFR_RESET_VAL),
            .WRITE_MASK(CSFR_REG_MASK[g])
         ) u_reg (
            .clk_sys(clk_sys),
            .rst(rst),
            .wrLo(wrLoOk && (wrHit.idx == csfr_idx_t'(g))),
            .wrHi(wrHiOk && (wrHit.idx == csfr_idx_t'(g))),
            .wrData(wrLane),
            .q(regQ[g])
         );
         assign regFlat[16*g +: 16] = regQ[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // peripheral regions belong to other maps; here they read zero
   always_comb begin
      rdMisaligned = !rdByte && rdAddr[0];
      rdWord = rdHit.hit ? regQ[rdHit.idx] : 16'h0000;
      if (rdByte) begin
         rdData_next = {8'h00, rdAddr[0] ? rdWord[15:8] : rdWord[7:0]};
      end else begin
         rdData_next = rdWord;                                     // misaligned reads complete
      end
   end

   // read answer registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdData <= 16'h0000;
         rdValid <= 1'b0;
         sfrSpaceHit <= 1'b0;
         sfrRegionHit <= 1'b0;
      end else begin
         rdValid <= rdEn;
         if (rdEn) begin
            rdData <= rdData_next;
            sfrSpaceHit <= rdSpace;
            sfrRegionHit <= rdRegion;
         end
      end
   end

   // ----------------------------------------------------------------
   // address error trap
   // ----------------------------------------------------------------
   // the trap is raised for either path; the store itself was
   // already blocked by the lane enables
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         addrErr <= 1'b0;
      end else begin
         addrErr <= (rdEn && rdMisaligned) || (wrEn && wrMisaligned);
      end
   end

   // ----------------------------------------------------------------
   // core state outputs
   // ----------------------------------------------------------------
   // copies lag the registers by one cycle; the cpu pipeline
   // already tolerates that for priority changes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cpuPriority <= 4'h0;
         visEnable <= 1'b0;
         repeatActive <= 1'b0;
      end else begin
         cpuPriority <= {regQ[CSFR_IDX_CORECTL][CSFR_CC_PRIO3_BIT],
                         regQ[CSFR_IDX_STATUS][CSFR_SR_PRIO_HI:CSFR_SR_PRIO_LO]};
         visEnable <= regQ[CSFR_IDX_CORECTL][CSFR_CC_VIS_BIT];
         repeatActive <= regQ[CSFR_IDX_STATUS][CSFR_SR_REPEAT_BIT];
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // reads off the register list answer zero
   unmapped_read_zero_a: assert property (
      rdEn && !rdHit.hit |=> rdValid && rdData == 16'h0000)
      else $error("unmapped read did not return zero");

   // space flag follows the 2 kbyte boundary
   sfr_space_bound_a: assert property (
      rdEn |=> sfrSpaceHit == ($past(rdAddr) <= CSFR_SPACE_LAST))
      else $error("sfr space flag wrong");

   // a register inside the space always lands in a used region
   region_hit_a: assert property (
      rdEn && rdHit.hit && rdAddr <= CSFR_SPACE_LAST |=> sfrRegionHit)
      else $error("register address outside a used region");

   // page placement: timers used, system page start empty
   region_pages_a: assert property (
      rdEn && (rdAddr == 16'h0100 || rdAddr == 16'h0700) |=>
         sfrRegionHit == ($past(rdAddr) == 16'h0100))
      else $error("page placement wrong");

   // status clears on reset and keeps only its nine bits
   status_reset_a: assert property (
      $past(rst) |-> regQ[CSFR_IDX_STATUS] == 16'h0000 && !repeatActive)
      else $error("status not clear after reset");

   status_field_a: assert property (
      wrEn && !wrByte && wrAddr == CSFR_REG_ADDR[CSFR_IDX_STATUS] |=>
         regQ[CSFR_IDX_STATUS] == ($past(wrData) & 16'h01ff) ##1
         cpuPriority[2:0] == regQ[CSFR_IDX_STATUS][7:5])
      else $error("status write or priority copy wrong");

   // core control keeps only bits 3 and 2
   corectl_mask_a: assert property (
      (regQ[CSFR_IDX_CORECTL] & 16'hfff3) == 16'h0000)
      else $error("core control holds unimplemented bits");

   // odd byte write keeps the low lane
   byte_lane_keep_a: assert property (
      wrEn && wrByte && wrAddr == 16'h0001 |=>
         regQ[CSFR_IDX_WORK0][7:0] == $past(regQ[CSFR_IDX_WORK0][7:0]) &&
         regQ[CSFR_IDX_WORK0][15:8] == $past(wrData[7:0]))
      else $error("byte write disturbed the other lane");

   // misaligned word store suppressed and trapped
   misaligned_store_a: assert property (
      wrEn && !wrByte && wrAddr == 16'h0003 |=>
         addrErr && regQ[CSFR_IDX_WORK1] == $past(regQ[CSFR_IDX_WORK1]))
      else $error("misaligned store not suppressed");

   // writes that hit nothing leave the whole bank alone
   unimpl_write_a: assert property (
      wrEn && !wrHit.hit |=> regFlat == $past(regFlat))
      else $error("ignored write changed a register");

   // every read is answered exactly one cycle later
   read_answer_a: assert property (
      rdEn |=> rdValid)
      else $error("read not answered");

   // the valid pulse never shows without a request
   read_idle_a: assert property (
      !rdEn |=> !rdValid)
      else $error("valid without a read");

   // a byte read leaves the upper half of the answer clear
   byte_read_hi_a: assert property (
      rdEn && rdByte |=> rdData[15:8] == 8'h00)
      else $error("byte read upper half not zero");

   // a misaligned word read completes but still traps
   read_trap_a: assert property (
      rdEn && !rdByte && rdAddr[0] |=> addrErr)
      else $error("misaligned read did not trap");

   // aligned and byte accesses never raise the trap
   no_false_trap_a: assert property (
      !(rdEn && !rdByte && rdAddr[0]) && !(wrEn && !wrByte && wrAddr[0]) |=> !addrErr)
      else $error("trap without a misaligned access");

   // even byte write keeps the high lane
   even_byte_keep_a: assert property (
      wrEn && wrByte && wrAddr == 16'h0000 |=>
         regQ[CSFR_IDX_WORK0][15:8] == $past(regQ[CSFR_IDX_WORK0][15:8]) &&
         regQ[CSFR_IDX_WORK0][7:0] == $past(wrData[7:0]))
      else $error("even byte write disturbed the high lane");

   // priority copy trails its register bits by one cycle
   prio_copy_a: assert property (
      cpuPriority == {$past(regQ[CSFR_IDX_CORECTL][CSFR_CC_PRIO3_BIT]),
                      $past(regQ[CSFR_IDX_STATUS][CSFR_SR_PRIO_HI:CSFR_SR_PRIO_LO])})
      else $error("priority copy wrong");

   // visibility copy trails its control bit by one cycle
   vis_copy_a: assert property (
      visEnable == $past(regQ[CSFR_IDX_CORECTL][CSFR_CC_VIS_BIT]))
      else $error("visibility copy wrong");

   // repeat copy trails its status bit by one cycle
   repeat_copy_a: assert property (
      repeatActive == $past(regQ[CSFR_IDX_STATUS][CSFR_SR_REPEAT_BIT]))
      else $error("repeat copy wrong");

   // answer and space flags stand until the next read
   read_hold_a: assert property (
      !rdEn |=> $stable(rdData) && $stable(sfrSpaceHit) && $stable(sfrRegionHit))
      else $error("read answer changed without a read");

   // main scenarios
   byte_read_c: cover property (rdEn && rdByte && rdHit.hit ##1 rdValid);
   word_write_c: cover property (wrEn && !wrByte && wrHit.hit && !wrAddr[0]);
   trap_c: cover property (wrEn && wrMisaligned ##1 addrErr);
   vis_on_c: cover property (visEnable && cpuPriority[3]);
   unmapped_read_c: cover property (rdEn && !rdHit.hit ##1 rdValid);

endmodule

// ===== logic/csfr_pkg.sv
// constants shared by the core special-function register bank
package csfr_pkg;

   // ----------------------------------------------------------------
   // data space and region layout
   // ----------------------------------------------------------------
   localparam logic [15:0] CSFR_SPACE_LAST = 16'h07ff;   // top byte of the sfr space
   localparam int CSFR_REGION_LSB = 5;                    // 32-byte region granule
   localparam int CSFR_REGION_MSB = 10;                   // 64 regions in 2 kbytes
   // one bit per 32-byte region, set where some register lives
   localparam logic [63:0] CSFR_REGION_USED = 64'h0c06_0000_0fcf_177f;

   // ----------------------------------------------------------------
   // register bank layout
   // ----------------------------------------------------------------
   localparam int CSFR_REG_COUNT = 25;                    // registers held here
   localparam int CSFR_IDX_W = 5;                         // width of a register index
   localparam logic [15:0] CSFR_RESET_VAL = 16'h0000;     // every register clears

   // byte address of each register, index order
   localparam logic [15:0] CSFR_REG_ADDR [CSFR_REG_COUNT] = '{
      16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h8000,  // work 0..4
      16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0012,  // work 5..9
      16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c,  // work 10..14
      16'h001e, 16'h0020, 16'h002e, 16'h0030, 16'h0032,  // work 15, limit, pc, table
      16'h0034, 16'h0036, 16'h0042, 16'h0044, 16'h0052   // vis, repeat, status, ctl, disi
   };

   // implemented bits of each register, index order
   localparam logic [15:0] CSFR_REG_MASK [CSFR_REG_COUNT] = '{
      16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
      16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
      16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
      16'hffff, 16'hffff, 16'hffff, 16'h007f, 16'h00ff,
      16'h00ff, 16'hffff, 16'h01ff, 16'h000c, 16'h3fff
   };

   localparam logic [CSFR_IDX_W-1:0] CSFR_IDX_WORK0 = 5'h00;    // first work register
   localparam logic [CSFR_IDX_W-1:0] CSFR_IDX_WORK1 = 5'h01;    // second work register
   localparam logic [CSFR_IDX_W-1:0] CSFR_IDX_STATUS = 5'h16;   // status_flags
   localparam logic [CSFR_IDX_W-1:0] CSFR_IDX_CORECTL = 5'h17;  // core_control

   // ----------------------------------------------------------------
   // status_flags fields
   // ----------------------------------------------------------------
   localparam int CSFR_SR_DCARRY_BIT = 8;     // digit_carry_flag
   localparam int CSFR_SR_PRIO_HI = 7;        // cpu_priority_level top
   localparam int CSFR_SR_PRIO_LO = 5;        // cpu_priority_level bottom
   localparam int CSFR_SR_REPEAT_BIT = 4;     // repeat_active_flag
   localparam int CSFR_SR_N_BIT = 3;          // negative
   localparam int CSFR_SR_OVFL_BIT = 2;       // overflow_flag
   localparam int CSFR_SR_Z_BIT = 1;          // zero
   localparam int CSFR_SR_C_BIT = 0;          // carry

   // ----------------------------------------------------------------
   // core_control fields
   // ----------------------------------------------------------------
   localparam int CSFR_CC_PRIO3_BIT = 3;      // fourth priority level bit
   localparam int CSFR_CC_VIS_BIT = 2;        // program_space_visibility enable

endpackage

// ===== logic/csfr_region_map.sv
// classifies a data address against the sfr space and its used regions
`timescale 1ns/1ps
module csfr_region_map
   import csfr_pkg::*;
(
   input wire logic [15:0] addr,      // byte address
   output logic inSpace,              // address lies in the sfr space
   output logic regionUsed            // its 32-byte region holds a register
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // core low in page 000h, timers page 100h, system page 700h
   // registers kept grouped per module, one bitmap bit per region
   always_comb begin
      inSpace = (addr <= CSFR_SPACE_LAST);
      regionUsed = inSpace && CSFR_REGION_USED[addr[CSFR_REGION_MSB:CSFR_REGION_LSB]];
   end

endmodule

// ===== logic/csfr_word_reg.sv
// one 16-bit register with separate byte lane writes and a bit mask
`timescale 1ns/1ps
module csfr_word_reg #(
   parameter logic [15:0] RESET_VAL = 16'h0000,   // value after reset
   parameter logic [15:0] WRITE_MASK = 16'hffff   // implemented bits
) (
   input wire logic clk_sys,          // system clock
   input wire logic rst,              // synchronous reset, high
   input wire logic wrLo,             // write low byte lane
   input wire logic wrHi,             // write high byte lane
   input wire logic [15:0] wrData,    // lane-aligned write data
   output logic [15:0] q              // register contents
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // unimplemented bits never load, so they read as zero forever
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= RESET_VAL & WRITE_MASK;
      end else begin
         if (wrLo) begin
            q[7:0] <= wrData[7:0] & WRITE_MASK[7:0];
         end
         if (wrHi) begin
            q[15:8] <= wrData[15:8] & WRITE_MASK[15:8];
         end
      end
   end

endmodule

// ===== tb/core_sfr_register_map_tb.sv
// self-checking bench for the core special-function register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin nFail++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module core_sfr_register_map_tb
   import csfr_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk_sys;                     // system clock, 5 ns
   logic rst;                         // synchronous reset
   logic rdEn, rdByte, wrEn, wrByte;  // request strobes
   logic [15:0] rdAddr, wrAddr, wrData, rdData;
   logic rdValid, sfrSpaceHit, sfrRegionHit, addrErr;
   logic [3:0] cpuPriority;           // priority level output
   logic visEnable, repeatActive;     // mirrored control bits
   int nFail = 0;                     // mismatches
   int cmpCount = 0;                  // comparisons made
   // unused addresses: space and region expectations per address
   localparam logic [15:0] UN_ADDR [9] = '{16'h0008, 16'h0060, 16'h00e0, 16'h0400,
                                          16'h0740, 16'h07fe, 16'h0800, 16'h0100, 16'h0700};
   localparam logic UN_SPACE [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   localparam logic UN_REGION [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

   // ----------------------------------------------------------------
   // clock and instances
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   csfr_core_bank dut (.clk_sys(clk_sys), .rst(rst), .rdEn(rdEn), .rdAddr(rdAddr),
      .rdByte(rdByte), .wrEn(wrEn), .wrAddr(wrAddr), .wrByte(wrByte), .wrData(wrData),
      .rdData(rdData), .rdValid(rdValid), .sfrSpaceHit(sfrSpaceHit),
      .sfrRegionHit(sfrRegionHit), .addrErr(addrErr), .cpuPriority(cpuPriority),
      .visEnable(visEnable), .repeatActive(repeatActive));

   csfr_cpu_agu_model agu (.clk_sys(clk_sys), .rdData(rdData), .rdValid(rdValid),
      .addrErr(addrErr), .rdEn(rdEn), .rdAddr(rdAddr), .rdByte(rdByte), .wrEn(wrEn),
      .wrAddr(wrAddr), .wrByte(wrByte), .wrData(wrData));

   // ----------------------------------------------------------------
   // helper tasks
   // ----------------------------------------------------------------
   // read and compare data plus the valid pulse
   task automatic rdChk(input logic [15:0] a, input logic b, input logic [15:0] e);
      logic [15:0] d;
      logic v;
      logic er;
      agu.rdAccess(a, b, d, v, er);
      `CHK($sformatf("valid %h", a), 1'b1, v)
      `CHK($sformatf("data %h", a), e, d)
   endtask

   // plain write, error pulse ignored
   task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d);
      logic er;
      agu.wrAccess(a, b, d, er);
   endtask

   // let the mirrored outputs catch up with a register write
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   // verdict, shared by the main sequence and the watchdog
   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", cmpCount, nFail);
      if (nFail == 0 && cmpCount > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // watchdog: the sequence needs well under 2000 cycles
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk_sys);
      nFail++;
      completeRun();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [15:0] d;
      logic v;
      logic er;
      rst = 1'b1;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      // every register clears, priority output zero
      for (int i = 0; i < CSFR_REG_COUNT; i++) begin
         rdChk(CSFR_REG_ADDR[i], 1'b0, 16'h0000);
      end
      `CHK("priority", 4'h0, cpuPriority)
      // all ones then all zeros: only implemented bits stick
      for (int i = 0; i < CSFR_REG_COUNT; i++) begin
         wr(CSFR_REG_ADDR[i], 1'b0, 16'hffff);
         rdChk(CSFR_REG_ADDR[i], 1'b0, CSFR_REG_MASK[i]);
         wr(CSFR_REG_ADDR[i], 1'b0, 16'h0000);
         rdChk(CSFR_REG_ADDR[i], 1'b0, 16'h0000);
      end
      // byte lanes, junk in the unused upper data lane
      wr(16'h0000, 1'b0, 16'h1234);
      wr(16'h0001, 1'b1, 16'h99ab);
      rdChk(16'h0000, 1'b0, 16'hab34);
      wr(16'h0000, 1'b1, 16'h77cd);
      rdChk(16'h0000, 1'b0, 16'habcd);
      rdChk(16'h0001, 1'b1, 16'h00ab);
      rdChk(16'h0000, 1'b1, 16'h00cd);
      // misaligned word accesses trap, the store is dropped
      wr(16'h0002, 1'b0, 16'h1111);
      agu.wrAccess(16'h0003, 1'b0, 16'h5555, er);
      `CHK("wr trap", 1'b1, er)
      rdChk(16'h0002, 1'b0, 16'h1111);
      agu.rdAccess(16'h0001, 1'b0, d, v, er);
      `CHK("rd trap", 1'b1, er)
      `CHK("rd trap data", 16'habcd, d)
      agu.rdAccess(16'h0001, 1'b1, d, v, er);
      `CHK("byte no trap", 1'b0, er)
      `CHK("byte hi data", 16'h00ab, d)
      // unused places read zero and swallow writes
      for (int i = 0; i < 9; i++) begin
         wr(UN_ADDR[i], 1'b0, 16'hffff);
         rdChk(UN_ADDR[i], 1'b0, 16'h0000);
         `CHK($sformatf("space %h", UN_ADDR[i]), UN_SPACE[i], sfrSpaceHit)
         `CHK($sformatf("region %h", UN_ADDR[i]), UN_REGION[i], sfrRegionHit)
      end
      rdChk(16'h0000, 1'b0, 16'habcd);
      // status and control fields reach the mirrored outputs
      wr(16'h0042, 1'b0, 16'h00f0);
      settle();
      `CHK("prio sr", 4'h7, cpuPriority)
      `CHK("repeat on", 1'b1, repeatActive)
      wr(16'h0044, 1'b0, 16'h0004);
      settle();
      `CHK("vis on", 1'b1, visEnable)
      `CHK("prio vis", 4'h7, cpuPriority)
      wr(16'h0044, 1'b0, 16'h0008);
      wr(16'h0042, 1'b0, 16'h0000);
      settle();
      `CHK("prio cc", 4'h8, cpuPriority)
      `CHK("vis off", 1'b0, visEnable)
      `CHK("repeat off", 1'b0, repeatActive)
      completeRun();
   end
endmodule

// ===== tb/csfr_cpu_agu_model.sv
// behavioural model of the cpu data-space read and write address units
`timescale 1ns/1ps
module csfr_cpu_agu_model
   import csfr_pkg::*;
(
   input wire logic clk_sys,          // system clock
   input wire logic [15:0] rdData,    // read answer from the bank
   input wire logic rdValid,          // read answer valid pulse
   input wire logic addrErr,          // misaligned access pulse
   output logic rdEn,                 // read request
   output logic [15:0] rdAddr,        // read byte address
   output logic rdByte,               // read is byte wide
   output logic wrEn,                 // write request
   output logic [15:0] wrAddr,        // write byte address
   output logic wrByte,               // write is byte wide
   output logic [15:0] wrData         // write data
);
   // ----------------------------------------------------------------
   // idle state at time zero
   // ----------------------------------------------------------------
   // idle lines carry junk so that a stale value is never read as valid
   initial begin
      rdEn = 1'b0;
      rdAddr = 16'ha5a5;
      rdByte = 1'b1;
      wrEn = 1'b0;
      wrAddr = 16'h5a5a;
      wrByte = 1'b1;
      wrData = 16'hc3c3;
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   // one write: drive after an edge, taken at the next, then release
   task automatic wrAccess(input logic [15:0] a, input logic b, input logic [15:0] d,
                           output logic err);
      @(posedge clk_sys);
      wrEn <= 1'b1;
      wrAddr <= a;
      wrByte <= b;
      wrData <= d;
      @(posedge clk_sys);
      wrEn <= 1'b0;
      wrAddr <= ~a;
      wrByte <= ~b;
      wrData <= ~d;
      #1;
      err = addrErr;
   endtask

   // one read: the answer is registered at the taking edge
   task automatic rdAccess(input logic [15:0] a, input logic b, output logic [15:0] d,
                           output logic v, output logic err);
      @(posedge clk_sys);
      rdEn <= 1'b1;
      rdAddr <= a;
      rdByte <= b;
      @(posedge clk_sys);
      rdEn <= 1'b0;
      rdAddr <= ~a;
      rdByte <= ~b;
      #1;
      d = rdData;
      v = rdValid;
      err = addrErr;
   endtask
endmodule
